// File: core/dual_serial_modem_pins.sv
// Purpose : pin control, modem status and strap capture for two serial ports
// Assumes : 200 MHz clk, sync reset sys_rst, Avalon-MM slave with waitrequest
// Notes   : the serial engine is not here; the transmit level is a control bit
`timescale 1ns/10ps

module dual_serial_modem_pins import serial_modem_pkg::*; (
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire av_req_type         avs_req,
   output      logic [DATA_W-1:0]  avs_readdata,
   output      logic               avs_waitrequest,
   output      logic               irq,
   input  wire logic               lpc_bus_reset_n,
   input  wire logic               serial_in_port_a,
   input  wire logic               serial_in_port_b,
   output      logic               serial_out_port_a_o,
   output      logic               serial_out_port_a_oe,
   input  wire logic               serial_out_port_a_i,
   output      logic               serial_out_port_b_o,
   output      logic               serial_out_port_b_oe,
   input  wire logic               serial_out_port_b_i,
   output      logic               request_send_a_n_o,
   output      logic               request_send_a_n_oe,
   input  wire logic               request_send_a_n_i,
   output      logic               request_send_b_n_o,
   output      logic               request_send_b_n_oe,
   input  wire logic               request_send_b_n_i,
   output      logic               terminal_ready_a_n_o,
   output      logic               terminal_ready_a_n_oe,
   input  wire logic               terminal_ready_a_n_i,
   output      logic               terminal_ready_b_n_o,
   output      logic               terminal_ready_b_n_oe,
   input  wire logic               terminal_ready_b_n_i,
   input  wire logic               data_set_ready_a_n,
   input  wire logic               data_set_ready_b_n,
   input  wire logic               clear_send_a_n,
   input  wire logic               clear_send_b_n,
   input  wire logic               ring_indicate_a_n,
   input  wire logic               ring_indicate_b_n,
   input  wire logic               carrier_detect_a_n,
   input  wire logic               carrier_detect_b_n
);

   localparam int SYNC_W = 17;
   // status and line pins idle high, so they reset high: no false change
   // flag follows reset; the bus reset bit resets low so straps are taken
   localparam logic [SYNC_W-1:0] SYNC_RST = 17'h0ffc0;

   typedef struct packed {
      logic [1:0][7:0]        mctl;
      logic [1:0][7:0]        mstat;
      logic [IRQ_W-1:0]       irq_stat;
      logic [IRQ_W-1:0]       irq_mask;
      logic [STRAP_W-1:0]     strap;
      logic                   bus_up_prev;
      logic                   drive_en;
      pin_out_type [1:0]      pins;
      logic                   ack;
      logic [DATA_W-1:0]      rdata;
   } state_type;

   state_type s_q;
   state_type s_d;

   logic [SYNC_W-1:0] raw_pins;
   logic [SYNC_W-1:0] sync_pins;

   // status levels, active high, per port: {dcd, ri, dsr, cts}
   logic [1:0][3:0]       modem_lvl;
   logic [1:0]            rx_lvl;
   logic [STRAP_W-1:0]    strap_pins;
   logic                  bus_up;
   logic                  req;
   logic                  do_write;
   logic                  do_read;
   logic                  wr_lane0;
   logic [7:0]            wbyte;

   // lpc reset is synchronised like any pin; reads as held-in-reset until seen
   assign raw_pins = {lpc_bus_reset_n,
                      serial_in_port_b, serial_in_port_a,
                      carrier_detect_b_n, ring_indicate_b_n,
                      data_set_ready_b_n, clear_send_b_n,
                      carrier_detect_a_n, ring_indicate_a_n,
                      data_set_ready_a_n, clear_send_a_n,
                      serial_out_port_b_i, request_send_b_n_i, terminal_ready_b_n_i,
                      serial_out_port_a_i, request_send_a_n_i, terminal_ready_a_n_i};

   sync_bits #(
      .WIDTH     (SYNC_W),
      .RESET_VAL (SYNC_RST)
   ) u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (raw_pins),
      .sync_out (sync_pins)
   );

   assign bus_up       = sync_pins[16];
   assign rx_lvl       = sync_pins[15:14];
   assign modem_lvl[1] = ~sync_pins[13:10];
   assign modem_lvl[0] = ~sync_pins[9:6];
   // strap order: option 1..6 = dtr a, rts a, sout a, dtr b, rts b, sout b
   assign strap_pins   = sync_pins[5:0];

   // an 8-bit register placed in the low lane of the data word
   function automatic logic [DATA_W-1:0] zext8(
      input logic [7:0] b
   );
      return {24'h000000, b};
   endfunction : zext8

   // next modem status: levels, change flags, ring trailing edge; set beats clear
   function automatic logic [7:0] mstat_next(
      input logic [7:0] old_st,
      input logic [3:0] lvl,
      input logic       clr
   );
      logic [7:0] nxt;
      logic [3:0] old_lvl;
      nxt     = old_st;
      old_lvl = old_st[MSTAT_DCD:MSTAT_CTS];
      if (clr) begin
         nxt[MSTAT_DDCD:MSTAT_DCTS] = 4'h0;
      end
      // clear-to-send moved either way
      if (lvl[0] != old_lvl[0]) begin
         nxt[MSTAT_DCTS] = 1'b1;
      end
      // data-set-ready moved either way
      if (lvl[1] != old_lvl[1]) begin
         nxt[MSTAT_DDSR] = 1'b1;
      end
      // ring flags only when the ring goes away, so one ring gives one flag
      if (old_lvl[2] && !lvl[2]) begin
         nxt[MSTAT_TERI] = 1'b1;
      end
      // carrier moved either way
      if (lvl[3] != old_lvl[3]) begin
         nxt[MSTAT_DDCD] = 1'b1;
      end
      nxt[MSTAT_DCD:MSTAT_CTS] = lvl;
      return nxt;
   endfunction : mstat_next

   // in loop mode the status follows the port's own control outputs
   function automatic logic [3:0] status_src(
      input logic [7:0] ctl,
      input logic [3:0] pin_lvl
   );
      logic [3:0] v;
      v = pin_lvl;
      if (ctl[MCTL_LOOP]) begin
         v = {ctl[MCTL_OUT2], ctl[MCTL_OUT1], ctl[MCTL_DTR], ctl[MCTL_RTS]};
      end
      return v;
   endfunction : status_src

   // a port's driven pin levels from its control byte
   function automatic pin_out_type pins_from_ctl(
      input logic [7:0] ctl
   );
      pin_out_type v;
      // the transmit level stands in for the engine; infrared keeps marking
      v.sout  = ctl[MCTL_TXD] | ctl[MCTL_IR];
      // loop mode keeps both handshakes inactive whatever the bits say
      v.rts_n = ~(ctl[MCTL_RTS] & ~ctl[MCTL_LOOP]);
      v.dtr_n = ~(ctl[MCTL_DTR] & ~ctl[MCTL_LOOP]);
      return v;
   endfunction : pins_from_ctl

   assign req      = avs_req.read | avs_req.write;
   assign do_write = avs_req.write & s_q.ack;
   assign do_read  = avs_req.read & s_q.ack;
   assign wr_lane0 = do_write & avs_req.byteenable[0];
   assign wbyte    = avs_req.writedata[7:0];

   always_comb begin
      logic [1:0]       clr_st;
      logic [1:0][7:0]  st_new;
      logic [IRQ_W-1:0] irq_set;
      s_d     = s_q;
      clr_st  = 2'b00;
      st_new  = s_q.mstat;
      irq_set = '0;

      // one wait cycle: read data is registered before waitrequest drops
      s_d.ack = req & ~s_q.ack;
      if (req && !s_q.ack) begin
         case (avs_req.address)
            OFF_MCTL_A : begin
               s_d.rdata = zext8(s_q.mctl[0]);
            end
            OFF_MCTL_B : begin
               s_d.rdata = zext8(s_q.mctl[1]);
            end
            OFF_MSTAT_A : begin
               s_d.rdata = zext8(s_q.mstat[0]);
            end
            OFF_MSTAT_B : begin
               s_d.rdata = zext8(s_q.mstat[1]);
            end
            OFF_IRQ_STAT : begin
               s_d.rdata = {29'h00000000, s_q.irq_stat};
            end
            OFF_IRQ_MASK : begin
               s_d.rdata = {29'h00000000, s_q.irq_mask};
            end
            OFF_STRAP : begin
               s_d.rdata = {26'h0000000, s_q.strap};
            end
            OFF_LINE : begin
               s_d.rdata = {30'h00000000, rx_lvl};
            end
            default : begin
               s_d.rdata = 32'h00000000;
            end
         endcase
      end

      // reading status clears its change flags at the accepting edge
      if (do_read && avs_req.address == OFF_MSTAT_A) begin
         clr_st[0] = 1'b1;
      end
      if (do_read && avs_req.address == OFF_MSTAT_B) begin
         clr_st[1] = 1'b1;
      end

      for (int p = 0; p < 2; p++) begin
         st_new[p] = mstat_next(s_q.mstat[p],
                                status_src(s_q.mctl[p], modem_lvl[p]),
                                clr_st[p]);
      end
      s_d.mstat = st_new;
      // only a flag going from clear to set raises the port's event
      irq_set[IRQ_MODEM_A] = |(st_new[0][MSTAT_DDCD:MSTAT_DCTS]
                               & ~s_q.mstat[0][MSTAT_DDCD:MSTAT_DCTS]);
      irq_set[IRQ_MODEM_B] = |(st_new[1][MSTAT_DDCD:MSTAT_DCTS]
                               & ~s_q.mstat[1][MSTAT_DDCD:MSTAT_DCTS]);

      // straps are taken on the release of the bus reset
      s_d.bus_up_prev = bus_up;
      if (bus_up && !s_q.bus_up_prev) begin
         s_d.strap          = strap_pins;
         irq_set[IRQ_STRAP] = 1'b1;
      end

      // pins are inputs while the bus reset is held
      s_d.drive_en = bus_up;

      if (wr_lane0) begin
         case (avs_req.address)
            OFF_MCTL_A : begin
               s_d.mctl[0] = wbyte;
            end
            OFF_MCTL_B : begin
               s_d.mctl[1] = wbyte;
            end
            OFF_IRQ_MASK : begin
               s_d.irq_mask = wbyte[IRQ_W-1:0];
            end
            OFF_IRQ_STAT : begin
               s_d.irq_stat = s_q.irq_stat & ~wbyte[IRQ_W-1:0];
            end
            default : begin
            end
         endcase
      end
      // a new event in the clearing cycle survives
      s_d.irq_stat = s_d.irq_stat | irq_set;

      // pins follow the control byte at the same edge that takes the write
      for (int p = 0; p < 2; p++) begin
         s_d.pins[p] = pins_from_ctl(s_d.mctl[p]);
      end

      if (sys_rst) begin
         s_d.mctl        = {MCTL_RST, MCTL_RST};
         s_d.mstat       = {MSTAT_RST, MSTAT_RST};
         s_d.irq_stat    = '0;
         s_d.irq_mask    = IRQ_MASK_RST;
         s_d.strap       = STRAP_RST;
         s_d.bus_up_prev = 1'b0;
         s_d.drive_en    = 1'b0;
         s_d.pins        = '1;
         s_d.ack         = 1'b0;
         s_d.rdata       = 32'h00000000;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign avs_waitrequest = req & ~s_q.ack;
   assign avs_readdata    = s_q.rdata;
   assign irq             = |(s_q.irq_stat & s_q.irq_mask);

   assign serial_out_port_a_o   = s_q.pins[0].sout;
   assign serial_out_port_b_o   = s_q.pins[1].sout;
   assign request_send_a_n_o    = s_q.pins[0].rts_n;
   assign request_send_b_n_o    = s_q.pins[1].rts_n;
   assign terminal_ready_a_n_o  = s_q.pins[0].dtr_n;
   assign terminal_ready_b_n_o  = s_q.pins[1].dtr_n;
   // all six strap pins release together while the bus reset is low
   assign serial_out_port_a_oe  = s_q.drive_en;
   assign serial_out_port_b_oe  = s_q.drive_en;
   assign request_send_a_n_oe   = s_q.drive_en;
   assign request_send_b_n_oe   = s_q.drive_en;
   assign terminal_ready_a_n_oe = s_q.drive_en;
   assign terminal_ready_b_n_oe = s_q.drive_en;

endmodule : dual_serial_modem_pins

// File: core/serial_modem_pkg.sv
// Purpose : shared constants and carrier types for the two-port serial modem pin block
// Assumes : Avalon-MM slave with byte addresses and 32-bit data
// Notes   : register offsets are byte addresses, one aligned word each
package serial_modem_pkg;

   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;

   // register offsets
   localparam logic [ADDR_W-1:0] OFF_MCTL_A   = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_MCTL_B   = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_MSTAT_A  = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_MSTAT_B  = 5'h0c;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_STRAP    = 5'h18;
   localparam logic [ADDR_W-1:0] OFF_LINE     = 5'h1c;

   // modem control field positions
   localparam int MCTL_DTR  = 0;
   localparam int MCTL_RTS  = 1;
   localparam int MCTL_OUT1 = 2;
   localparam int MCTL_OUT2 = 3;
   localparam int MCTL_LOOP = 4;
   localparam int MCTL_IR   = 6;
   localparam int MCTL_TXD  = 7;

   // modem status field positions
   localparam int MSTAT_DCTS = 0;
   localparam int MSTAT_DDSR = 1;
   localparam int MSTAT_TERI = 2;
   localparam int MSTAT_DDCD = 3;
   localparam int MSTAT_CTS  = 4;
   localparam int MSTAT_DSR  = 5;
   localparam int MSTAT_RI   = 6;
   localparam int MSTAT_DCD  = 7;

   // interrupt field positions
   localparam int IRQ_MODEM_A = 0;
   localparam int IRQ_MODEM_B = 1;
   localparam int IRQ_STRAP   = 2;
   localparam int IRQ_W       = 3;

   localparam int STRAP_W = 6;

   // reset values; transmit level idles at marking
   localparam logic [7:0]         MCTL_RST     = 8'h80;
   localparam logic [7:0]         MSTAT_RST    = 8'h00;
   localparam logic [IRQ_W-1:0]   IRQ_MASK_RST = 3'h0;
   localparam logic [STRAP_W-1:0] STRAP_RST    = 6'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic              read;
      logic              write;
      logic [DATA_W-1:0] writedata;
      logic [3:0]        byteenable;
   } av_req_type;

   // one port's driven pin levels
   typedef struct packed {
      logic sout;
      logic rts_n;
      logic dtr_n;
   } pin_out_type;

endpackage : serial_modem_pkg

// File: core/sync_bits.sv
// Purpose : two-flop synchroniser for a bundle of asynchronous pins
// Assumes : one clock, synchronous active-high reset
// Notes   : first stage is read only by the second stage
`timescale 1ns/10ps
module sync_bits #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_type;

   sync_state_type s_q;
   sync_state_type s_d;

   always_comb begin
      s_d        = s_q;
      s_d.meta   = async_in;
      s_d.stable = s_q.meta;
      if (sys_rst) begin
         s_d.meta   = RESET_VAL;
         s_d.stable = RESET_VAL;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign sync_out = s_q.stable;

endmodule : sync_bits

// File: tb/pins_monitor.sv
// Purpose: concurrent checks on pin levels and output enables
// Assumes: one clock, sync active-high sys_rst
// Notes: sees top ports only; bound below
`timescale 1ns/10ps
module pins_monitor import serial_modem_pkg::*; (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire av_req_type avs_req,
   input wire logic       avs_waitrequest,
   input wire logic       lpc_bus_reset_n,
   input wire logic       serial_out_port_a_o,
   input wire logic       serial_out_port_a_oe,
   input wire logic       serial_out_port_b_o,
   input wire logic       request_send_a_n_o,
   input wire logic       request_send_a_n_oe,
   input wire logic       request_send_b_n_o,
   input wire logic       request_send_b_n_oe,
   input wire logic       terminal_ready_a_n_o,
   input wire logic       terminal_ready_b_n_o
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic              wa;
   logic              wb;
   logic [DATA_W-1:0] wd;
   assign wd = avs_req.writedata;
   // an accepted control write, or reset, is the only thing allowed to move a control pin
   assign wa = avs_req.write && !avs_waitrequest && avs_req.byteenable[0]
               && avs_req.address == OFF_MCTL_A;
   assign wb = avs_req.write && !avs_waitrequest && avs_req.byteenable[0]
               && avs_req.address == OFF_MCTL_B;
   AST_RST_SOUT: assert property (disable iff (1'b0)
      sys_rst |=> serial_out_port_a_o && serial_out_port_b_o) else $error("sout not idle");
   AST_RST_RTS: assert property (disable iff (1'b0)
      sys_rst |=> request_send_a_n_o && request_send_b_n_o) else $error("rts active");
   AST_RST_DTR: assert property (disable iff (1'b0)
      sys_rst |=> terminal_ready_a_n_o && terminal_ready_b_n_o) else $error("dtr active");
   AST_RTS_A: assert property (wa |=>
      request_send_a_n_o == !($past(wd[MCTL_RTS]) && !$past(wd[MCTL_LOOP])))
      else $error("rts a wrong");
   AST_DTR_B: assert property (wb |=>
      terminal_ready_b_n_o == !($past(wd[MCTL_DTR]) && !$past(wd[MCTL_LOOP])))
      else $error("dtr b wrong");
   AST_SOUT_A: assert property (wa && !wd[MCTL_LOOP] |=>
      serial_out_port_a_o == ($past(wd[MCTL_TXD]) || $past(wd[MCTL_IR])))
      else $error("sout a wrong");
   AST_RTS_HOLD: assert property ($changed(request_send_a_n_o) |->
      $past(wa) || $past(sys_rst)) else $error("rts a moved alone");
   AST_STRAP_OE: assert property (!lpc_bus_reset_n [*4] |->
      !serial_out_port_a_oe && !request_send_b_n_oe) else $error("driving in bus reset");
   AST_DRIVE_OE: assert property (lpc_bus_reset_n [*6] |->
      request_send_a_n_oe && request_send_b_n_oe) else $error("not driving");
   cover property (wa && wd[MCTL_LOOP]);
   cover property (wb && wd[MCTL_DTR]);
   cover property ($rose(lpc_bus_reset_n));
endmodule : pins_monitor

bind dual_serial_modem_pins pins_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
   .avs_req(avs_req), .avs_waitrequest(avs_waitrequest), .lpc_bus_reset_n(lpc_bus_reset_n),
   .serial_out_port_a_o(serial_out_port_a_o), .serial_out_port_a_oe(serial_out_port_a_oe),
   .serial_out_port_b_o(serial_out_port_b_o), .request_send_a_n_o(request_send_a_n_o),
   .request_send_a_n_oe(request_send_a_n_oe), .request_send_b_n_o(request_send_b_n_o),
   .request_send_b_n_oe(request_send_b_n_oe), .terminal_ready_a_n_o(terminal_ready_a_n_o),
   .terminal_ready_b_n_o(terminal_ready_b_n_o));

// File: tb/modem_model.sv
// Purpose: modem status lines and strap pulls on the far side
// Assumes: bench commands the status levels
// Notes: pin order dtr_a, rts_a, sout_a, dtr_b, rts_b, sout_b
`timescale 1ns/10ps
module modem_model (
   input  wire logic [5:0] pin_o,
   input  wire logic [5:0] pin_oe,
   input  wire logic [5:0] strap,
   input  wire logic [7:0] status_n,
   input  wire logic [1:0] rx,
   output      logic [5:0] pin_i,
   output      logic [3:0] port_a_n,
   output      logic [3:0] port_b_n,
   output      logic [1:0] serial_in
);
   // a released pin falls to its pull, never keeps the last driven value
   assign pin_i     = (pin_oe & pin_o) | (~pin_oe & strap);
   assign port_a_n  = status_n[3:0];
   assign port_b_n  = status_n[7:4];
   assign serial_in = rx;
endmodule : modem_model

// File: tb/dual_serial_modem_pins_tb.sv
// Purpose: self-checking bench for the two-port pin block
// Assumes: 200 MHz clk, Avalon master with waitrequest
// Notes: status order per port is cts, dsr, ri, dcd
`timescale 1ns/10ps
module dual_serial_modem_pins_tb import serial_modem_pkg::*;;
   localparam logic [7:0] MV [5] = '{8'h83, 8'h93, 8'h40, 8'h03, 8'h00};
   localparam logic [2:0] EV [5] = '{3'b100, 3'b011, 3'b111, 3'b000, 3'b011};
   // sout in loop mode still follows the transmit and infrared bits, but is masked out
   localparam logic [2:0] MK [5] = '{3'h7, 3'h3, 3'h7, 3'h7, 3'h7};
   logic              clk, sys_rst, lpc_n, wreq, irq;
   av_req_type        req;
   logic [DATA_W-1:0] rdata, rd;
   logic [5:0]        po, poe, pi, strap;
   logic [7:0]        status_n;
   logic [3:0]        pa_n, pb_n;
   logic [1:0]        rx, sin;
   int                errors, checks_done;

   dual_serial_modem_pins u_dut (.clk(clk), .sys_rst(sys_rst), .avs_req(req),
      .avs_readdata(rdata), .avs_waitrequest(wreq), .irq(irq), .lpc_bus_reset_n(lpc_n),
      .serial_in_port_a(sin[0]), .serial_in_port_b(sin[1]),
      .serial_out_port_a_o(po[2]), .serial_out_port_a_oe(poe[2]), .serial_out_port_a_i(pi[2]),
      .serial_out_port_b_o(po[5]), .serial_out_port_b_oe(poe[5]), .serial_out_port_b_i(pi[5]),
      .request_send_a_n_o(po[1]), .request_send_a_n_oe(poe[1]), .request_send_a_n_i(pi[1]),
      .request_send_b_n_o(po[4]), .request_send_b_n_oe(poe[4]), .request_send_b_n_i(pi[4]),
      .terminal_ready_a_n_o(po[0]), .terminal_ready_a_n_oe(poe[0]),
      .terminal_ready_a_n_i(pi[0]), .terminal_ready_b_n_o(po[3]),
      .terminal_ready_b_n_oe(poe[3]), .terminal_ready_b_n_i(pi[3]),
      .clear_send_a_n(pa_n[0]), .data_set_ready_a_n(pa_n[1]), .ring_indicate_a_n(pa_n[2]),
      .carrier_detect_a_n(pa_n[3]), .clear_send_b_n(pb_n[0]), .data_set_ready_b_n(pb_n[1]),
      .ring_indicate_b_n(pb_n[2]), .carrier_detect_b_n(pb_n[3]));
   modem_model u_modem (.pin_o(po), .pin_oe(poe), .strap(strap), .status_n(status_n),
      .rx(rx), .pin_i(pi), .port_a_n(pa_n), .port_b_n(pb_n), .serial_in(sin));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      req.address   <= a;
      req.writedata <= {24'h0, d};
      req.write     <= 1'b1;
      do @(posedge clk); while (wreq !== 1'b0);
      req.write <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge clk);
      req.address <= a;
      req.read    <= 1'b1;
      do @(posedge clk); while (wreq !== 1'b0);
      d = rdata;
      req.read <= 1'b0;
   endtask : bus_rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic t_reset;
      #1;
      chk(32'(po), 32'h3f);
      bus_rd(OFF_MCTL_A, rd);
      chk(rd, 32'h80);
   endtask : t_reset

   task automatic t_mcr;
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 5; i++) begin
            bus_wr(p ? OFF_MCTL_B : OFF_MCTL_A, MV[i]);
            settle(2);
            chk(32'(3'(po >> 3*p) & MK[i]), 32'(EV[i] & MK[i]));
            bus_rd(p ? OFF_MCTL_B : OFF_MCTL_A, rd);
            chk(rd, 32'(MV[i]));
         end
         bus_wr(p ? OFF_MCTL_B : OFF_MCTL_A, 8'h80);
      end
   endtask : t_mcr

   task automatic t_msr;
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            status_n <= ~(8'h01 << (4 * p + k));
            rx       <= p ? 2'b01 : 2'b10;
            settle(5);
            bus_rd(p ? OFF_MSTAT_B : OFF_MSTAT_A, rd);
            chk(32'(rd[7:4]), 32'h1 << k);
            bus_rd(OFF_LINE, rd);
            chk(32'(rd[1:0]), p ? 32'h1 : 32'h2);
         end
      end
      status_n <= 8'hff;
      rx       <= 2'b11;
   endtask : t_msr

   task automatic t_irq;
      bus_wr(OFF_IRQ_MASK, 8'h00);
      settle(5);
      bus_wr(OFF_IRQ_STAT, 8'h07);
      status_n <= 8'hfe;
      settle(5);
      bus_rd(OFF_IRQ_STAT, rd);
      chk(32'(rd[IRQ_MODEM_A]), 32'h1);
      chk(32'(irq), 32'h0);
      bus_wr(OFF_IRQ_MASK, 8'h01);
      settle(2);
      chk(32'(irq), 32'h1);
      status_n <= 8'hff;
      settle(5);
      bus_wr(OFF_IRQ_STAT, 8'h01);
      settle(2);
      chk(32'(irq), 32'h0);
      bus_rd(5'h1e, rd);
      chk(rd, 32'h0);
   endtask : t_irq

   task automatic t_strap(input logic [5:0] s);
      @(posedge clk);
      strap <= s;
      lpc_n <= 1'b0;
      settle(6);
      chk(32'(poe), 32'h0);
      lpc_n <= 1'b1;
      settle(8);
      chk(32'(poe), 32'h3f);
      bus_rd(OFF_STRAP, rd);
      chk(rd, 32'(s));
   endtask : t_strap

   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop();
   end

   initial begin
      sys_rst  = 1'b1;
      lpc_n    = 1'b1;
      req      = '0;
      req.byteenable = 4'hf;
      strap    = 6'h2d;
      status_n = 8'hff;
      rx       = 2'b11;
      errors   = 0;
      checks_done = 0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_mcr();
      t_msr();
      t_irq();
      t_strap(6'h2d);
      t_strap(6'h12);
      report_and_stop();
   end
endmodule : dual_serial_modem_pins_tb
